// >>> design/usm_serial_pins.sv
// quad serial channel pin logic: nrz or infrared line, modem and flow-control pins
//
// Notes on behaviour
// - with infrared select low a channel sends and receives plain nrz serial data.
// - in nrz mode the transmit pin is high during reset and whenever nothing is sent.
// - with infrared select high transmit and receive use irda coding and the pin idles low.
// - the dedicated infrared transmit pin always carries irda coded data and idles low.
// - infrared receive idles low and a software bit may invert it before the decoder.
// - the active-low rts pin is a general output that auto rts can release while data waits.
// - the active-low cts pin is a general input and can gate the start of each sent byte.
// - the active-low dtr pin is driven from software as modem control or general output.
// - dsr, cd and ri are sampled and reported either as modem status or general inputs.
`timescale 1ns/1ps
module usm_serial_pins (
  // clock and reset
  input  wire logic                                               clk,
  input  wire logic                                               reset_n,
  // per-channel configuration
  input  wire usm_pkg::usm_chan_cfg_t [usm_pkg::CHANNELS-1:0]     chan_cfg,
  // transmit byte stream from the user side
  input  wire logic [usm_pkg::CHANNELS-1:0]                       tx_valid,
  input  wire logic [usm_pkg::CHANNELS-1:0][usm_pkg::DATA_W-1:0]  tx_data,
  output logic      [usm_pkg::CHANNELS-1:0]                       tx_ready,
  // received bytes to the user side
  output logic      [usm_pkg::CHANNELS-1:0]                       rx_valid,
  output logic      [usm_pkg::CHANNELS-1:0][usm_pkg::DATA_W-1:0]  rx_data,
  output logic      [usm_pkg::CHANNELS-1:0]                       rx_frame_err,
  input  wire logic [usm_pkg::CHANNELS-1:0]                       rx_ready,
  // serial line pins
  output logic      [usm_pkg::CHANNELS-1:0]                       tx_out,
  output logic      [usm_pkg::CHANNELS-1:0]                       infrared_tx_out,
  input  wire logic [usm_pkg::CHANNELS-1:0]                       rx_in,
  // modem pins, active low
  output logic      [usm_pkg::CHANNELS-1:0]                       rts_n,
  output logic      [usm_pkg::CHANNELS-1:0]                       dtr_n,
  input  wire logic [usm_pkg::CHANNELS-1:0]                       cts_n,
  input  wire logic [usm_pkg::CHANNELS-1:0]                       dsr_n,
  input  wire logic [usm_pkg::CHANNELS-1:0]                       carrier_detect_n,
  input  wire logic [usm_pkg::CHANNELS-1:0]                       ring_indicator_n,
  // sampled modem status, active high
  output usm_pkg::usm_modem_stat_t [usm_pkg::CHANNELS-1:0]        modem_stat
);

  for (genvar ch = 0; ch < usm_pkg::CHANNELS; ch++) begin : g_chan
    usm_pkg::usm_chan_cfg_t          cfg;
    logic                            f_valid;
    logic [usm_pkg::DATA_W-1:0]      f_data;
    logic                            f_ready;
    logic                            cts_ok;
    logic                            ir_enc;
    logic                            rx_raw;
    usm_pkg::usm_tx_state_t          tx_state_reg;
    logic [15:0]                     tx_cnt_reg;
    logic [3:0]                      tx_bit_reg;
    logic [usm_pkg::DATA_W-1:0]      tx_sh_reg;
    logic                            tx_line_reg;
    logic                            tx_out_reg;
    logic                            ir_out_reg;
    logic [15:0]                     stretch_reg;
    logic                            rx_line_reg;
    usm_pkg::usm_rx_state_t          rx_state_reg;
    logic [15:0]                     rx_cnt_reg;
    logic [3:0]                      rx_bit_reg;
    logic [usm_pkg::DATA_W-1:0]      rx_sh_reg;
    logic                            rx_done_reg;
    logic                            rx_bad_reg;
    logic                            rx_valid_reg;
    logic [usm_pkg::DATA_W-1:0]      rx_data_reg;
    logic                            rx_err_reg;
    logic                            rts_n_reg;
    logic                            dtr_n_reg;
    usm_pkg::usm_modem_stat_t        stat_reg;

    assign cfg = chan_cfg[ch];

    // ---------------------------------------------------------------
    // transmit buffer
    // ---------------------------------------------------------------
    usm_fifo #(
      .WIDTH (usm_pkg::DATA_W),
      .DEPTH (usm_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (tx_valid[ch]),
      .in_data   (tx_data[ch]),
      .in_ready  (tx_ready[ch]),
      .out_valid (f_valid),
      .out_data  (f_data),
      .out_ready (f_ready)
    );

    // cts is only looked at between bytes, so a byte already started always completes
    assign cts_ok  = !cfg.auto_cts || !cts_n[ch];
    assign f_ready = (tx_state_reg == usm_pkg::TX_IDLE) && cts_ok;

    // ---------------------------------------------------------------
    // transmit serialiser
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        tx_state_reg <= usm_pkg::TX_IDLE;
        tx_cnt_reg   <= usm_pkg::CNT_ZERO;
        tx_bit_reg   <= usm_pkg::BIT_ZERO;
        tx_sh_reg    <= '0;
        tx_line_reg  <= usm_pkg::NRZ_IDLE;
      end else begin
        case (tx_state_reg)
          usm_pkg::TX_IDLE: begin
            tx_line_reg <= usm_pkg::NRZ_IDLE;
            tx_cnt_reg  <= usm_pkg::CNT_ZERO;
            if (f_valid && f_ready) begin
              tx_sh_reg    <= f_data;
              tx_line_reg  <= 1'b0;
              tx_state_reg <= usm_pkg::TX_START;
            end
          end
          usm_pkg::TX_START: begin
            if (usm_pkg::usm_bit_done(tx_cnt_reg)) begin
              tx_cnt_reg   <= usm_pkg::CNT_ZERO;
              tx_bit_reg   <= usm_pkg::BIT_ZERO;
              tx_line_reg  <= tx_sh_reg[0];
              tx_state_reg <= usm_pkg::TX_DATA;
            end else begin
              tx_cnt_reg <= tx_cnt_reg + usm_pkg::CNT_ONE;
            end
          end
          usm_pkg::TX_DATA: begin
            if (usm_pkg::usm_bit_done(tx_cnt_reg)) begin
              tx_cnt_reg <= usm_pkg::CNT_ZERO;
              if (tx_bit_reg == usm_pkg::LAST_BIT) begin
                tx_line_reg  <= usm_pkg::NRZ_IDLE;
                tx_state_reg <= usm_pkg::TX_STOP;
              end else begin
                tx_bit_reg  <= tx_bit_reg + usm_pkg::BIT_ONE;
                tx_sh_reg   <= tx_sh_reg >> 1;
                tx_line_reg <= tx_sh_reg[1];
              end
            end else begin
              tx_cnt_reg <= tx_cnt_reg + usm_pkg::CNT_ONE;
            end
          end
          usm_pkg::TX_STOP: begin
            if (usm_pkg::usm_bit_done(tx_cnt_reg)) begin
              tx_cnt_reg   <= usm_pkg::CNT_ZERO;
              tx_state_reg <= usm_pkg::TX_IDLE;
            end else begin
              tx_cnt_reg <= tx_cnt_reg + usm_pkg::CNT_ONE;
            end
          end
          default: begin
            tx_state_reg <= usm_pkg::TX_IDLE;
          end
        endcase
      end
    end

    // pulse at the head of every zero bit, start bit included
    assign ir_enc = (tx_state_reg != usm_pkg::TX_IDLE) && !tx_line_reg
                    && (tx_cnt_reg < usm_pkg::IR_PULSE_CYC);

    // ---------------------------------------------------------------
    // transmit pins
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        tx_out_reg <= usm_pkg::NRZ_IDLE;
        ir_out_reg <= usm_pkg::IR_IDLE;
      end else begin
        tx_out_reg <= cfg.ir_select ? ir_enc : tx_line_reg;
        ir_out_reg <= ir_enc;
      end
    end

    // ---------------------------------------------------------------
    // receive front end and infrared decoder
    // ---------------------------------------------------------------
    assign rx_raw = rx_in[ch] ^ (cfg.ir_select && cfg.rx_invert);

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        stretch_reg <= usm_pkg::CNT_ZERO;
        rx_line_reg <= usm_pkg::NRZ_IDLE;
      end else if (cfg.ir_select) begin
        // a short pulse becomes a low level long enough to cover mid-bit sampling
        if (rx_raw) begin
          stretch_reg <= usm_pkg::STRETCH_CYC;
        end else if (stretch_reg != usm_pkg::CNT_ZERO) begin
          stretch_reg <= stretch_reg - usm_pkg::CNT_ONE;
        end
        rx_line_reg <= !(rx_raw || stretch_reg != usm_pkg::CNT_ZERO);
      end else begin
        stretch_reg <= usm_pkg::CNT_ZERO;
        rx_line_reg <= rx_raw;
      end
    end

    // ---------------------------------------------------------------
    // receive deserialiser
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        rx_state_reg <= usm_pkg::RX_IDLE;
        rx_cnt_reg   <= usm_pkg::CNT_ZERO;
        rx_bit_reg   <= usm_pkg::BIT_ZERO;
        rx_sh_reg    <= '0;
        rx_done_reg  <= 1'b0;
        rx_bad_reg   <= 1'b0;
      end else begin
        rx_done_reg <= 1'b0;
        rx_bad_reg  <= 1'b0;
        case (rx_state_reg)
          usm_pkg::RX_IDLE: begin
            rx_cnt_reg <= usm_pkg::CNT_ZERO;
            if (!rx_line_reg) begin
              rx_state_reg <= usm_pkg::RX_START;
            end
          end
          usm_pkg::RX_START: begin
            if (rx_cnt_reg == usm_pkg::HALF_CYC - usm_pkg::CNT_ONE) begin
              rx_cnt_reg   <= usm_pkg::CNT_ZERO;
              rx_bit_reg   <= usm_pkg::BIT_ZERO;
              // a glitch shorter than half a bit is dropped
              rx_state_reg <= rx_line_reg ? usm_pkg::RX_IDLE : usm_pkg::RX_DATA;
            end else begin
              rx_cnt_reg <= rx_cnt_reg + usm_pkg::CNT_ONE;
            end
          end
          usm_pkg::RX_DATA: begin
            if (usm_pkg::usm_bit_done(rx_cnt_reg)) begin
              rx_cnt_reg <= usm_pkg::CNT_ZERO;
              rx_sh_reg  <= {rx_line_reg, rx_sh_reg[usm_pkg::DATA_W-1:1]};
              if (rx_bit_reg == usm_pkg::LAST_BIT) begin
                rx_state_reg <= usm_pkg::RX_STOP;
              end else begin
                rx_bit_reg <= rx_bit_reg + usm_pkg::BIT_ONE;
              end
            end else begin
              rx_cnt_reg <= rx_cnt_reg + usm_pkg::CNT_ONE;
            end
          end
          usm_pkg::RX_STOP: begin
            if (usm_pkg::usm_bit_done(rx_cnt_reg)) begin
              rx_cnt_reg   <= usm_pkg::CNT_ZERO;
              rx_state_reg <= usm_pkg::RX_IDLE;
              rx_done_reg  <= rx_line_reg;
              rx_bad_reg   <= !rx_line_reg;
            end else begin
              rx_cnt_reg <= rx_cnt_reg + usm_pkg::CNT_ONE;
            end
          end
          default: begin
            rx_state_reg <= usm_pkg::RX_IDLE;
          end
        endcase
      end
    end

    // ---------------------------------------------------------------
    // receive holding register; a new byte overwrites an unread one
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        rx_valid_reg <= 1'b0;
        rx_data_reg  <= '0;
        rx_err_reg   <= 1'b0;
      end else begin
        rx_err_reg <= rx_bad_reg;
        if (rx_done_reg) begin
          rx_valid_reg <= 1'b1;
          rx_data_reg  <= rx_sh_reg;
        end else if (rx_ready[ch]) begin
          rx_valid_reg <= 1'b0;
        end
      end
    end

    // ---------------------------------------------------------------
    // modem pins and status
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        rts_n_reg <= usm_pkg::PIN_OFF;
        dtr_n_reg <= usm_pkg::PIN_OFF;
        stat_reg  <= usm_pkg::STAT_RESET;
      end else begin
        // auto rts only releases the pin; software must have asserted it first
        rts_n_reg <= !(cfg.rts_on && !(cfg.auto_rts && rx_valid_reg));
        dtr_n_reg <= !cfg.dtr_on;
        stat_reg  <= '{cts: !cts_n[ch], dsr: !dsr_n[ch],
                       cd: !carrier_detect_n[ch], ri: !ring_indicator_n[ch]};
      end
    end

    assign tx_out[ch]          = tx_out_reg;
    assign infrared_tx_out[ch] = ir_out_reg;
    assign rx_valid[ch]        = rx_valid_reg;
    assign rx_data[ch]         = rx_data_reg;
    assign rx_frame_err[ch]    = rx_err_reg;
    assign rts_n[ch]           = rts_n_reg;
    assign dtr_n[ch]           = dtr_n_reg;
    assign modem_stat[ch]      = stat_reg;
  end

endmodule

// >>> design/usm_pkg.sv
// shared constants, carriers and helpers for the quad serial pin block
package usm_pkg;

  // ---------------------------------------------------------------
  // channel count and timing
  // ---------------------------------------------------------------
  localparam int          CHANNELS     = 4;
  localparam int          CLK_HZ       = 50_000_000;
  localparam int          BAUD_HZ      = 115_200;
  localparam logic [15:0] BIT_CYC      = 16'(CLK_HZ / BAUD_HZ);
  localparam logic [15:0] HALF_CYC     = 16'(CLK_HZ / BAUD_HZ / 2);
  // infrared pulse is three sixteenths of a bit
  localparam logic [15:0] IR_PULSE_CYC = 16'(CLK_HZ / BAUD_HZ * 3 / 16);
  // decoder holds a received pulse as a low level for three quarters of a bit
  localparam logic [15:0] STRETCH_CYC  = 16'(CLK_HZ / BAUD_HZ * 3 / 4);
  localparam logic [15:0] CNT_ZERO     = 16'h0000;
  localparam logic [15:0] CNT_ONE      = 16'h0001;
  localparam int          DATA_W       = 8;
  localparam logic [3:0]  LAST_BIT     = 4'h7;
  localparam logic [3:0]  BIT_ZERO     = 4'h0;
  localparam logic [3:0]  BIT_ONE      = 4'h1;
  localparam int          FIFO_DEPTH   = 4;

  // ---------------------------------------------------------------
  // line levels
  // ---------------------------------------------------------------
  localparam logic NRZ_IDLE = 1'b1;
  localparam logic IR_IDLE  = 1'b0;
  localparam logic PIN_OFF  = 1'b1;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ir_select;
    logic rx_invert;
    logic rts_on;
    logic dtr_on;
    logic auto_rts;
    logic auto_cts;
  } usm_chan_cfg_t;

  typedef struct packed {
    logic cts;
    logic dsr;
    logic cd;
    logic ri;
  } usm_modem_stat_t;

  localparam usm_modem_stat_t STAT_RESET = '0;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } usm_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } usm_rx_state_t;

  function automatic logic usm_bit_done(input logic [15:0] cnt);
    return cnt == BIT_CYC - CNT_ONE;
  endfunction

endpackage

// >>> design/usm_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module usm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0]   FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
  localparam logic [PW-1:0] PTR_ONE  = PW'(1);
  localparam logic [PW:0]   CNT_ONE  = (PW + 1)'(1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = count_reg != FULL_CNT;
  assign out_valid = count_reg != '0;
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + PTR_ONE;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + PTR_ONE;
      end
      if (push && !pop) begin
        count_reg <= count_reg + CNT_ONE;
      end else if (pop && !push) begin
        count_reg <= count_reg - CNT_ONE;
      end
    end
  end

endmodule

// >>> bench/usm_pins_props.sv
// pin timing checker for the quad serial pin block
`timescale 1ns/1ps
module usm_pins_props (
  // clock and reset
  input wire logic                           clk,
  input wire logic                           reset_n,
  // configuration and receive handshake
  input wire usm_pkg::usm_chan_cfg_t [3:0]   chan_cfg,
  input wire logic [3:0]                     rx_valid,
  input wire logic [3:0]                     rx_ready,
  // serial and modem pins
  input wire logic [3:0]                     tx_out,
  input wire logic [3:0]                     infrared_tx_out,
  input wire logic [3:0]                     rts_n,
  input wire logic [3:0]                     dtr_n,
  input wire logic [3:0]                     cts_n,
  input wire logic [3:0]                     dsr_n,
  input wire logic [3:0]                     carrier_detect_n,
  input wire logic [3:0]                     ring_indicator_n,
  // sampled status
  input wire usm_pkg::usm_modem_stat_t [3:0] modem_stat
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  for (genvar c = 0; c < 4; c++) begin : g_chan
    logic [7:0] ir_run;
    // length of the current high run on the dedicated infrared pin
    always_ff @(posedge clk) begin
      if (!reset_n || !infrared_tx_out[c]) begin
        ir_run <= 8'h00;
      end else begin
        ir_run <= ir_run + 8'h01;
      end
    end
    reset_idle_a: assert property (
      !$past(reset_n) |-> tx_out[c] && !infrared_tx_out[c] && rts_n[c] && dtr_n[c])
      else $error("pins not idle after reset");
    ir_pulse_width_a: assert property (
      $fell(infrared_tx_out[c]) |-> ir_run == 8'(usm_pkg::IR_PULSE_CYC))
      else $error("infrared pulse length off");
    ir_line_same_a: assert property (
      $past(chan_cfg[c].ir_select, 2) && $past(chan_cfg[c].ir_select) && chan_cfg[c].ir_select
      |-> tx_out[c] == infrared_tx_out[c])
      else $error("infrared mode line differs from infrared pin");
    nrz_ir_align_a: assert property (
      !chan_cfg[c].ir_select && $fell(tx_out[c]) |-> $rose(infrared_tx_out[c]))
      else $error("zero bit without infrared pulse");
    dtr_level_a: assert property (
      $past(reset_n) |-> dtr_n[c] == !$past(chan_cfg[c].dtr_on))
      else $error("dtr pin wrong");
    rts_level_a: assert property (
      $past(reset_n) |-> rts_n[c] == !($past(chan_cfg[c].rts_on)
      && !($past(chan_cfg[c].auto_rts) && $past(rx_valid[c]))))
      else $error("rts pin wrong");
    modem_status_a: assert property (
      $past(reset_n) |-> 4'(modem_stat[c]) == ~$past({cts_n[c], dsr_n[c],
      carrier_detect_n[c], ring_indicator_n[c]}))
      else $error("modem status wrong");
    rx_hold_a: assert property (
      rx_valid[c] && !rx_ready[c] |=> rx_valid[c])
      else $error("received byte lost");
  end
endmodule

bind usm_serial_pins usm_pins_props usm_pins_props_inst (
  .clk(clk), .reset_n(reset_n), .chan_cfg(chan_cfg), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .tx_out(tx_out), .infrared_tx_out(infrared_tx_out),
  .rts_n(rts_n), .dtr_n(dtr_n), .cts_n(cts_n), .dsr_n(dsr_n),
  .carrier_detect_n(carrier_detect_n), .ring_indicator_n(ring_indicator_n),
  .modem_stat(modem_stat)
);

// >>> bench/usm_far_end.sv
// far-end model: transceiver and modem driving receive and modem pins, decoding transmit
`timescale 1ns/1ps
module usm_far_end (
  // clock
  input  wire logic       clk,
  // serial lines
  input  wire logic [3:0] tx_out,
  input  wire logic [3:0] infrared_tx_out,
  output logic      [3:0] rx_in,
  // modem inputs, active low
  output logic      [3:0] cts_n,
  output logic      [3:0] dsr_n,
  output logic      [3:0] carrier_detect_n,
  output logic      [3:0] ring_indicator_n
);
  localparam int BIT   = int'(usm_pkg::BIT_CYC);
  localparam int PULSE = int'(usm_pkg::IR_PULSE_CYC);
  initial begin
    rx_in = 4'hf;
    {cts_n, dsr_n, carrier_detect_n, ring_indicator_n} = 16'hffff;
  end
  task automatic set_modem(input int ch, input logic [3:0] v);
    {cts_n[ch], dsr_n[ch], carrier_detect_n[ch], ring_indicator_n[ch]} = v;
  endtask
  // infrared sends a short high pulse per zero bit, optionally inverted
  task automatic send(input int ch, input bit ir, input bit inv, input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      for (int n = 0; n < BIT; n++) begin
        @(negedge clk);
        rx_in[ch] = ir ? ((!f[k] && n < PULSE) ^ inv) : f[k];
      end
    end
  endtask
  function automatic logic line(input int ch, input bit ded);
    return ded ? infrared_tx_out[ch] : tx_out[ch];
  endfunction
  // nrz sampled mid-bit; infrared early, then the pulse must be over
  task automatic recv(input int ch, input bit ir, input bit ded,
                      output logic [7:0] b, output bit ok);
    logic [9:0] f;
    int n;
    n = 0;
    ok = 1'b1;
    while (line(ch, ded) !== ir && n < 30000) begin
      @(negedge clk);
      n++;
    end
    repeat (ir ? 40 : BIT / 2) @(negedge clk);
    for (int k = 0; k < 10; k++) begin
      if (k != 0) repeat (ir ? BIT - 60 : BIT) @(negedge clk);
      f[k] = line(ch, ded) ^ ir;
      if (ir) begin
        repeat (60) @(negedge clk);
        if (line(ch, ded) !== 1'b0) ok = 1'b0;
      end
    end
    b = f[8:1];
    if (f[0] !== 1'b0 || f[9] !== 1'b1 || n >= 30000) ok = 1'b0;
  endtask
endmodule

// >>> bench/tb.sv
// self-checking bench for the quad serial pin block
`timescale 1ns/1ps
module tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic                           clk;
  logic                           reset_n;
  usm_pkg::usm_chan_cfg_t [3:0]   chan_cfg;
  logic [3:0]                     tx_valid, tx_ready, rx_valid, rx_frame_err, rx_ready;
  logic [3:0][7:0]                tx_data, rx_data;
  logic [3:0]                     tx_out, infrared_tx_out, rx_in, rts_n, dtr_n;
  logic [3:0]                     cts_n, dsr_n, carrier_detect_n, ring_indicator_n;
  usm_pkg::usm_modem_stat_t [3:0] modem_stat;
  int                             fail_count = 0;
  int                             compares = 0;
  int                             cycles = 0;
  logic [7:0]                     got [4];
  bit                             ok [4];
  logic [3:0]                     err_seen = '0;

  usm_serial_pins usm_serial_pins_inst (
    .clk(clk), .reset_n(reset_n), .chan_cfg(chan_cfg), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_frame_err(rx_frame_err), .rx_ready(rx_ready), .tx_out(tx_out),
    .infrared_tx_out(infrared_tx_out), .rx_in(rx_in), .rts_n(rts_n), .dtr_n(dtr_n),
    .cts_n(cts_n), .dsr_n(dsr_n), .carrier_detect_n(carrier_detect_n),
    .ring_indicator_n(ring_indicator_n), .modem_stat(modem_stat));
  usm_far_end usm_far_end_inst (
    .clk(clk), .tx_out(tx_out), .infrared_tx_out(infrared_tx_out), .rx_in(rx_in),
    .cts_n(cts_n), .dsr_n(dsr_n), .carrier_detect_n(carrier_detect_n),
    .ring_indicator_n(ring_indicator_n));

  // ---------------------------------------------------------------
  // clock, watchdog and helpers
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) err_seen |= rx_frame_err;
  // ceiling about twice the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // call at a falling edge; valid stays up unless last
  task automatic put_byte(input int ch, input logic [7:0] b, input bit last);
    int n;
    tx_valid[ch] = 1'b1;
    tx_data[ch] = b;
    n = 0;
    while (tx_ready[ch] !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    if (last) tx_valid[ch] = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    chan_cfg = '0;
    tx_valid = '0;
    tx_data = '0;
    rx_ready = '0;
    repeat (2) @(negedge clk);
    check("tx_out in reset", 8'h0f, {4'h0, tx_out});
    check("infrared in reset", 8'h00, {4'h0, infrared_tx_out});
    reset_n = 1'b1;
    for (int ch = 0; ch < 4; ch++) begin
      chan_cfg[ch].dtr_on = ch[0];
      chan_cfg[ch].rts_on = !ch[0];
      usm_far_end_inst.set_modem(ch, ~(4'h1 << ch));
    end
    repeat (3) @(negedge clk);
    for (int ch = 0; ch < 4; ch++) begin
      check("modem_stat", 8'(4'h1 << ch), 8'(modem_stat[ch]));
      check("dtr_n", 8'(!ch[0]), 8'(dtr_n[ch]));
      check("rts_n", 8'(ch[0]), 8'(rts_n[ch]));
      usm_far_end_inst.set_modem(ch, 4'hf);
    end
    // nrz on channel 0 while channel 1 sends infrared
    chan_cfg[1].ir_select = 1'b1;
    usm_far_end_inst.rx_in[1] = 1'b0;
    repeat (3) @(negedge clk);
    fork
      put_byte(0, 8'ha5, 1'b1);
      put_byte(1, 8'h3c, 1'b1);
      usm_far_end_inst.recv(0, 1'b0, 1'b0, got[0], ok[0]);
      usm_far_end_inst.recv(0, 1'b1, 1'b1, got[1], ok[1]);
      usm_far_end_inst.recv(1, 1'b1, 1'b0, got[2], ok[2]);
    join
    check("nrz byte", 8'ha5, got[0]);
    check("dedicated ir byte", 8'ha5, got[1]);
    check("ir byte", 8'h3c, got[2]);
    check("frames", 8'h07, {5'h00, ok[2], ok[1], ok[0]});
    repeat (500) @(negedge clk);
    check("idle lines", 8'h01, {6'h00, tx_out[1:0]});
    check("idle infrared", 8'h00, {4'h0, infrared_tx_out});
    // receive nrz with auto rts, and inverted infrared
    chan_cfg[2].rts_on = 1'b1;
    chan_cfg[2].auto_rts = 1'b1;
    chan_cfg[3].ir_select = 1'b1;
    chan_cfg[3].rx_invert = 1'b1;
    repeat (3) @(negedge clk);
    check("rts_n before", 8'h00, 8'(rts_n[2]));
    fork
      usm_far_end_inst.send(2, 1'b0, 1'b0, 8'h96);
      usm_far_end_inst.send(3, 1'b1, 1'b1, 8'h4b);
    join
    repeat (4) @(negedge clk);
    check("rx_valid set", 8'h03, {6'h00, rx_valid[3:2]});
    check("rx_data nrz", 8'h96, rx_data[2]);
    check("rx_data ir", 8'h4b, rx_data[3]);
    check("rts_n released", 8'h01, 8'(rts_n[2]));
    rx_ready = 4'hc;
    @(negedge clk);
    rx_ready = 4'h0;
    repeat (2) @(negedge clk);
    check("rx_valid clear", 8'h00, {6'h00, rx_valid[3:2]});
    check("rts_n again", 8'h00, 8'(rts_n[2]));
    // clear-to-send holds a full buffer until asserted
    chan_cfg[3] = '0;
    chan_cfg[3].auto_cts = 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 4; i++) put_byte(3, {4'(i), 4'h9}, i == 3);
    repeat (500) @(negedge clk);
    check("tx held", 8'h01, 8'(tx_out[3]));
    check("tx_ready full", 8'h00, 8'(tx_ready[3]));
    fork
      usm_far_end_inst.set_modem(3, 4'h7);
      for (int i = 0; i < 4; i++) usm_far_end_inst.recv(3, 1'b0, 1'b0, got[i], ok[i]);
    join
    for (int i = 0; i < 4; i++) begin
      check("drained byte", {4'(i), 4'h9}, got[i]);
      check("drained frame", 8'h01, 8'(ok[i]));
    end
    check("tx_ready empty", 8'h01, 8'(tx_ready[3]));
    usm_far_end_inst.rx_in[0] = 1'b0;
    repeat (4200) @(negedge clk);
    usm_far_end_inst.rx_in[0] = 1'b1;
    repeat (300) @(negedge clk);
    check("frame error", 8'h01, {rx_valid[0], 3'h0, err_seen});
    report_and_stop();
  end
endmodule
